// ---- can_accept_filter_bit_sync.sv ----
// Purpose: can receive acceptance filtering and bit-timing synchronisation
// Assumes: frame decoder delivers identifiers on rx_id with a one-cycle rx_id_valid
// Notes: registers over apb; the pin can_rx passes two flip-flops before use
`timescale 1ns/1ns
`default_nettype none
module can_accept_filter_bit_sync
  import can_filter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [can_filter_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx,
  output logic can_tx,
  input wire logic tx_dominant,
  input wire logic bus_idle,
  input wire logic [can_filter_pkg::ID_W-1:0] rx_id,
  input wire logic rx_id_valid,
  input wire logic rx_buffer_zero_full,
  output logic store_valid,
  output logic [3:0] store_buffer,
  output logic [4:0] filter_hit_field,
  output logic sample_point,
  output logic sampled_bit,
  output logic hard_sync,
  output logic resync
);
  import can_filter_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [TIM_W-1:0] timing;
    logic [NUM_FILT-1:0] fen;
    logic [4*NUM_FILT-1:0] assoc;
    logic [2*NUM_FILT-1:0] msel;
    logic [ID_W-1:0] mask0;
    logic [ID_W-1:0] mask1;
    logic [NUM_FILT-1:0][ID_W-1:0] filt;
    logic [31:0] rdata;
    logic err;
    logic [4:0] last_hit;
    logic [3:0] last_buf;
    logic st_valid;
    logic [3:0] st_buf;
    logic [4:0] st_hit;
    logic rx_s1;
    logic rx_s2;
    logic rx_q;
    logic sampled;
    logic smp_pulse;
    logic synced;
    logic [5:0] tq_cnt;
    seg_e seg;
    logic [4:0] seg_cnt;
    logic [2:0] ext;
    logic [2:0] shrt;
    logic edge_pend;
    logic hard_pulse;
    logic resync_pulse;
    logic tx;
  } state_s;

  state_s q;
  state_s d;

  logic is_config;
  logic is_normal;
  logic legacy;
  logic [2:0] sjw_len;
  logic [4:0] t1_len;
  logic [4:0] t2_len;
  logic [NUM_FILT-1:0] match;
  logic [NUM_FILT-1:0] eligible;

  assign is_config = q.ctrl[CTRL_OP_LSB +: 2] == OP_CONFIG;
  assign is_normal = q.ctrl[CTRL_OP_LSB +: 2] == OP_NORMAL;
  assign legacy = q.ctrl[CTRL_FUNC_LSB +: 2] == FUNC_LEGACY;
  assign sjw_len = {1'b0, q.ctrl[CTRL_SJW_LSB +: 2]} + 3'h1;
  assign t1_len = {1'b0, q.timing[TIM_T1_LSB +: 4]} + 5'h01 + {2'h0, q.ext};
  // shortening never takes segment two below one quantum
  assign t2_len = ({1'b0, q.timing[TIM_T2_LSB +: 4]} + 5'h01 > {2'h0, q.shrt}) ?
                  {1'b0, q.timing[TIM_T2_LSB +: 4]} + 5'h01 - {2'h0, q.shrt} : 5'h01;

  // per-filter compare: masked identifier bits must equal the filter bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
      logic [1:0] sel;
      logic [ID_W-1:0] msk;
      if (gi < 2) begin : g_leg0
        assign sel = legacy ? MSEL_MASK0 : q.msel[2*gi +: 2];
      end else begin : g_leg1
        assign sel = legacy ? MSEL_MASK1 : q.msel[2*gi +: 2];
      end
      // unused code 3 selects no mask, so the filter accepts any identifier
      assign msk = (sel == MSEL_MASK0) ? q.mask0 :
                   (sel == MSEL_MASK1) ? q.mask1 :
                   (sel == MSEL_F15) ? q.filt[NUM_FILT-1] : '0;
      assign match[gi] = eligible[gi] && (((rx_id ^ q.filt[gi]) & msk) == '0);
      // legacy mode has six filters, all live; modes 1/2 use the enables
      if (gi < 6) begin : g_six
        assign eligible[gi] = legacy ? 1'b1 : q.fen[gi];
      end else if (gi == NUM_FILT - 1) begin : g_last
        assign eligible[gi] = !legacy && q.fen[gi] && !q.ctrl[CTRL_F15MASK_BIT];
      end else begin : g_mid
        assign eligible[gi] = !legacy && q.fen[gi];
      end
    end
  endgenerate

  // next-state logic for registers, filter result and bit timing
  always_comb begin
    logic acc;
    logic setup;
    logic wr;
    logic mapped;
    logic locked;
    logic found;
    logic [4:0] win;
    logic tick;
    logic edge_ok;
    logic [4:0] err_mag;
    logic [31:0] rd;
    logic [3:0] fidx;
    acc = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    mapped = 1'b0;
    locked = 1'b0;
    found = 1'b0;
    win = 5'h00;
    tick = 1'b0;
    edge_ok = 1'b0;
    err_mag = 5'h00;
    rd = 32'h0000_0000;
    fidx = paddr[5:2];
    d = q;

    // apb decode; read data and error are captured in the setup cycle
    setup = psel && !penable;
    acc = psel && penable;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_CTRL: rd = {24'h00_0000, q.ctrl};
      ADDR_TIMING: rd = {18'h0_0000, q.timing};
      ADDR_FEN: rd = {16'h0000, q.fen};
      ADDR_ASSOC0: rd = q.assoc[31:0];
      ADDR_ASSOC1: rd = q.assoc[63:32];
      ADDR_MSEL: rd = q.msel;
      ADDR_MASK0: rd = {3'h0, q.mask0};
      ADDR_MASK1: rd = {3'h0, q.mask1};
      ADDR_STATUS: rd = {20'h0_0000, is_normal, q.synced, q.sampled, q.last_buf, q.last_hit};
      default: begin
        if (paddr[11:6] == ADDR_FILT_BASE[11:6] && paddr[1:0] == 2'h0) begin
          rd = {3'h0, q.filt[fidx]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
    // everything except control is frozen outside configuration; status is never writable
    locked = !is_config && paddr != ADDR_CTRL;
    if (setup) begin
      d.rdata = pwrite ? 32'h0000_0000 : rd;
      d.err = !mapped || (pwrite && (locked || paddr == ADDR_STATUS));
    end
    wr = acc && pwrite && !q.err;
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: d.ctrl = pwdata[CTRL_W-1:0];
        ADDR_TIMING: d.timing = pwdata[TIM_W-1:0];
        ADDR_FEN: d.fen = pwdata[NUM_FILT-1:0];
        ADDR_ASSOC0: d.assoc[31:0] = pwdata;
        ADDR_ASSOC1: d.assoc[63:32] = pwdata;
        ADDR_MSEL: d.msel = pwdata;
        ADDR_MASK0: d.mask0 = pwdata[ID_W-1:0];
        ADDR_MASK1: d.mask1 = pwdata[ID_W-1:0];
        default: d.filt[fidx] = pwdata[ID_W-1:0];
      endcase
    end

    // descending scan so the lowest matching filter is kept
    for (int i = NUM_FILT - 1; i >= 0; i--) begin
      if (match[i]) begin
        found = 1'b1;
        win = i[4:0];
      end
    end
    d.st_valid = 1'b0;
    if (rx_id_valid && is_normal && found) begin
      d.st_valid = 1'b1;
      if (!legacy) begin
        d.st_buf = q.assoc[4*win[3:0] +: 4];
        d.st_hit = win;
      end else if (win > 5'h01) begin
        d.st_buf = BUF_ONE;
        d.st_hit = win;
      end else if (rx_buffer_zero_full && q.ctrl[CTRL_ROLL_BIT]) begin
        d.st_buf = BUF_ONE;
        d.st_hit = win;
      end else begin
        d.st_buf = BUF_ZERO;
        d.st_hit = win[0] ? HIT_B0_F1 : HIT_B0_F0;
      end
      d.last_buf = d.st_buf;
      d.last_hit = d.st_hit;
    end

    // transmit path only opens in normal mode; recessive otherwise
    d.tx = !(is_normal && tx_dominant);

    // pin synchroniser, then falling-edge detection on the settled copy
    d.rx_s1 = can_rx;
    d.rx_s2 = q.rx_s1;
    d.rx_q = q.rx_s2;
    tick = q.tq_cnt == q.timing[TIM_BRP_LSB +: 6];
    d.tq_cnt = tick ? 6'h00 : q.tq_cnt + 6'h01;
    d.edge_pend = (q.edge_pend && !tick) || (q.rx_q && !q.rx_s2);
    d.smp_pulse = 1'b0;
    d.hard_pulse = 1'b0;
    d.resync_pulse = 1'b0;

    if (tick) begin
      // an edge counts only when the last sample was recessive
      edge_ok = q.edge_pend && q.sampled && !q.synced;
      // default progress through the bit
      unique case (q.seg)
        seg_sync: begin
          d.seg = seg_tseg1;
          d.seg_cnt = 5'h00;
          d.synced = 1'b0;
          d.ext = 3'h0;
          d.shrt = 3'h0;
        end
        seg_tseg1: begin
          if (q.seg_cnt >= t1_len - 5'h01) begin
            d.seg = seg_tseg2;
            d.seg_cnt = 5'h00;
            d.smp_pulse = 1'b1;
            d.sampled = q.rx_q;
          end else begin
            d.seg_cnt = q.seg_cnt + 5'h01;
          end
        end
        seg_tseg2: begin
          if (q.seg_cnt >= t2_len - 5'h01) begin
            d.seg = seg_sync;
            d.seg_cnt = 5'h00;
          end else begin
            d.seg_cnt = q.seg_cnt + 5'h01;
          end
        end
      endcase
      if (edge_ok && bus_idle) begin
        // hard sync: the edge becomes the sync segment of a fresh bit
        d.seg = seg_tseg1;
        d.seg_cnt = 5'h00;
        d.ext = 3'h0;
        d.shrt = 3'h0;
        d.synced = 1'b1;
        d.hard_pulse = 1'b1;
        d.smp_pulse = 1'b0;
        d.sampled = q.sampled;
      end else if (edge_ok) begin
        unique case (q.seg)
          seg_sync: d.synced = 1'b1;
          seg_tseg1: begin
            err_mag = q.seg_cnt + 5'h01;
            if (!tx_dominant) begin
              d.synced = 1'b1;
              d.resync_pulse = 1'b1;
              if (err_mag <= {2'h0, sjw_len}) begin
                d.seg = seg_tseg1;
                d.seg_cnt = 5'h00;
                d.ext = 3'h0;
                d.smp_pulse = 1'b0;
                d.sampled = q.sampled;
              end else begin
                d.ext = sjw_len;
                d.seg = seg_tseg1;
                d.seg_cnt = q.seg_cnt + 5'h01;
                d.smp_pulse = 1'b0;
                d.sampled = q.sampled;
              end
            end
          end
          seg_tseg2: begin
            err_mag = t2_len - q.seg_cnt;
            d.synced = 1'b1;
            d.resync_pulse = 1'b1;
            if (err_mag <= {2'h0, sjw_len}) begin
              d.seg = seg_tseg1;
              d.seg_cnt = 5'h00;
              d.ext = 3'h0;
              d.shrt = 3'h0;
            end else begin
              d.shrt = sjw_len;
            end
          end
        endcase
      end
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.timing <= TIMING_RST;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.rx_q <= 1'b1;
      q.sampled <= 1'b1;
      q.tx <= 1'b1;
      q.seg <= seg_sync;
    end else begin
      q <= d;
    end
  end

  // zero-wait slave: access phase always completes
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = psel && penable && q.err;
  assign can_tx = q.tx;
  assign store_valid = q.st_valid;
  assign store_buffer = q.st_buf;
  assign filter_hit_field = q.st_hit;
  assign sample_point = q.smp_pulse;
  assign sampled_bit = q.sampled;
  assign hard_sync = q.hard_pulse;
  assign resync = q.resync_pulse;

  property p_write_lock;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == ADDR_FILT_BASE && !is_config)
      |=> (q.filt[0] == $past(q.filt[0]));
  endproperty
  a_write_lock: assert property (p_write_lock) else $error("filter changed outside config");

  property p_no_match;
    @(posedge pclk) disable iff (!presetn)
      (rx_id_valid && match == '0) |=> !store_valid;
  endproperty
  a_no_match: assert property (p_no_match) else $error("stored without a match");

  property p_lowest;
    @(posedge pclk) disable iff (!presetn)
      (rx_id_valid && is_normal && !legacy && match[0])
      |=> (store_valid && filter_hit_field == 5'h00);
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest filter not reported");

  property p_rollover;
    @(posedge pclk) disable iff (!presetn)
      (rx_id_valid && is_normal && legacy && match[1] && !match[0] && rx_buffer_zero_full
       && q.ctrl[CTRL_ROLL_BIT])
      |=> (store_buffer == BUF_ONE && filter_hit_field == 5'h01);
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover code wrong");

  property p_one_sync;
    @(posedge pclk) disable iff (!presetn)
      (hard_sync || resync) |-> !$past(q.synced);
  endproperty
  a_one_sync: assert property (p_one_sync) else $error("second sync in one bit");

  property p_tx_pos;
    @(posedge pclk) disable iff (!presetn)
      (resync && $past(q.seg) == seg_tseg1) |-> !$past(tx_dominant);
  endproperty
  a_tx_pos: assert property (p_tx_pos) else $error("positive resync while dominant");

  property p_tx_normal;
    @(posedge pclk) disable iff (!presetn)
      (!is_normal && $past(!is_normal)) |-> can_tx;
  endproperty
  a_tx_normal: assert property (p_tx_normal) else $error("dominant outside normal");

  property p_lengthen;
    @(posedge pclk) disable iff (!presetn)
      (q.ext != 3'h0 && $past(q.ext) == 3'h0) |-> (q.ext == sjw_len && resync);
  endproperty
  a_lengthen: assert property (p_lengthen) else $error("lengthening not jump width");

  property p_hard;
    @(posedge pclk) disable iff (!presetn)
      hard_sync |-> (q.seg == seg_tseg1 && q.seg_cnt == 5'h00 && q.synced && $past(bus_idle));
  endproperty
  a_hard: assert property (p_hard) else $error("hard sync did not restart");
endmodule : can_accept_filter_bit_sync
`default_nettype wire

// ---- can_filter_pkg.sv ----
// Purpose: shared constants for the can acceptance filter and bit sync block
// Assumes: apb slave with 12-bit byte address and 32-bit data
// Notes: every register takes one aligned word; unlisted bits read as zero
package can_filter_pkg;
  localparam int unsigned NUM_FILT = 16;
  localparam int unsigned ID_W = 29;
  localparam int unsigned ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TIMING = 12'h004;
  localparam logic [11:0] ADDR_FEN = 12'h008; // filter_enable_register
  localparam logic [11:0] ADDR_ASSOC0 = 12'h00c; // filter_buffer_assoc_register, filters 0-7
  localparam logic [11:0] ADDR_ASSOC1 = 12'h010; // filters 8-15
  localparam logic [11:0] ADDR_MSEL = 12'h014; // mask_select_register
  localparam logic [11:0] ADDR_MASK0 = 12'h018;
  localparam logic [11:0] ADDR_MASK1 = 12'h01c;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  localparam logic [11:0] ADDR_FILT_BASE = 12'h040; // filter n at base + 4*n

  // control register fields
  localparam int unsigned CTRL_OP_LSB = 0; // 2 bits, operating mode
  localparam int unsigned CTRL_FUNC_LSB = 2; // 2 bits, functional mode 0/1/2
  localparam int unsigned CTRL_ROLL_BIT = 4; // rollover_enable
  localparam int unsigned CTRL_SJW_LSB = 5; // 2 bits, jump width minus one
  localparam int unsigned CTRL_F15MASK_BIT = 7; // filter_fifteen acts as a mask
  localparam int unsigned CTRL_W = 8;
  localparam logic [1:0] OP_CONFIG = 2'h0;
  localparam logic [1:0] OP_NORMAL = 2'h1;
  localparam logic [1:0] FUNC_LEGACY = 2'h0;

  // timing register fields (lengths in time quanta, minus one)
  localparam int unsigned TIM_T1_LSB = 0; // 4 bits, propagation plus phase segment 1
  localparam int unsigned TIM_T2_LSB = 4; // 4 bits, phase segment 2
  localparam int unsigned TIM_BRP_LSB = 8; // 6 bits, quantum prescaler
  localparam int unsigned TIM_W = 14;

  // mask selection codes, two bits per filter
  localparam logic [1:0] MSEL_MASK0 = 2'h0;
  localparam logic [1:0] MSEL_MASK1 = 2'h1;
  localparam logic [1:0] MSEL_F15 = 2'h2;

  // status register fields
  localparam int unsigned ST_HIT_LSB = 0; // 5 bits, last filter_hit_field
  localparam int unsigned ST_BUF_LSB = 5; // 4 bits, last target buffer
  localparam int unsigned ST_SAMPLED_BIT = 9;
  localparam int unsigned ST_SYNCED_BIT = 10;
  localparam int unsigned ST_NORMAL_BIT = 11;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00; // configuration mode, legacy mode
  localparam logic [TIM_W-1:0] TIMING_RST = 14'h0034; // 5 tq + 4 tq, prescaler 1

  // legacy mode filter_hit_field codes for filters 0 and 1 kept in rx_buffer_zero
  localparam logic [4:0] HIT_B0_F0 = 5'h06;
  localparam logic [4:0] HIT_B0_F1 = 5'h07;
  localparam logic [3:0] BUF_ZERO = 4'h0;
  localparam logic [3:0] BUF_ONE = 4'h1;

  typedef enum logic [1:0] {seg_sync, seg_tseg1, seg_tseg2} seg_e;
endpackage : can_filter_pkg

// ---- can_node_model.sv ----
// Purpose: behavioural model of the other nodes sharing the can bus
// Assumes: wired-and bus, 1 recessive, pulled recessive when nobody drives dominant
// Notes: the bench decides when the other nodes drive; the model only keeps the wire honest
`timescale 1ns/1ns
`default_nettype none
module can_node_model (
  input wire logic pclk,
  input wire logic can_tx,
  output logic can_rx
);
  logic node_r;

  initial node_r = 1'b1;

  // wired-and: any dominant node wins, otherwise the pull-up gives recessive
  assign can_rx = can_tx & node_r;

  // levels change just after an edge so the design never races the stimulus
  task automatic drive(input logic lvl);
    @(posedge pclk);
    node_r <= lvl;
  endtask : drive
endmodule : can_node_model
`default_nettype wire

// ---- test_can_accept_filter_bit_sync.sv ----
// Purpose: self-checking bench for acceptance filtering and bit synchronisation
// Assumes: apb master in the bench, other bus nodes in can_node_model
// Notes: one clock per quantum (reset timing), so a bit lasts ten clocks
`timescale 1ns/1ns
`default_nettype none
module test_can_accept_filter_bit_sync;
  import can_filter_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic can_tx, can_rx, tx_dominant, bus_idle, rx_id_valid, rx_buffer_zero_full;
  logic store_valid, sample_point, sampled_bit, hard_sync, resync;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [28:0] rx_id;
  logic [3:0] store_buffer;
  logic [4:0] filter_hit_field;
  int n_errors, tests_run, hs, rs;

  can_accept_filter_bit_sync DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .can_rx, .can_tx, .tx_dominant, .bus_idle,
    .rx_id, .rx_id_valid, .rx_buffer_zero_full, .store_valid, .store_buffer,
    .filter_hit_field, .sample_point, .sampled_bit, .hard_sync, .resync);
  can_node_model node (.pclk, .can_tx, .can_rx);

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // a slave that never answers is a mismatch, not a silent pass
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr on write", e, err);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rd);
  endtask : rdc

  // one identifier; the store answer stands in the following cycle only
  task automatic send(input logic [28:0] id, input logic v, input logic [3:0] b,
                      input logic [4:0] h);
    @(posedge pclk);
    rx_id <= id;
    rx_id_valid <= 1'b1;
    @(posedge pclk);
    rx_id_valid <= 1'b0;
    #1;
    chk("store_valid", v, store_valid);
    if (v) begin
      chk("store_buffer", b, store_buffer);
      chk("filter_hit_field", h, filter_hit_field);
    end
  endtask : send

  // count sync pulses over a window of clocks
  task automatic watch(input int lim);
    hs = 0;
    rs = 0;
    repeat (lim) begin
      @(posedge pclk);
      #1;
      hs += int'(hard_sync === 1'b1);
      rs += int'(resync === 1'b1);
    end
  endtask : watch

  task automatic wait_sp();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (sample_point !== 1'b1 && k < 40);
    chk("sample point seen", 1, int'(k < 40));
  endtask : wait_sp

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the whole run needs a few hundred clocks
  initial begin
    #(100 * 30000);
    n_errors++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, tx_dominant, rx_id_valid, rx_buffer_zero_full} = '0;
    bus_idle = 1'b1;
    paddr = '0;
    pwdata = '0;
    rx_id = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, refused accesses
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_TIMING, 32'h34);
    wr(ADDR_STATUS, 32'h0, 1'b1);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    // no dominant bits leave the pin outside normal mode
    tx_dominant <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk("can_tx config", 1, can_tx);
    // legacy setup: exact masks, filter n holds 'h100 + n
    for (int n = 0; n < 6; n++) wr(ADDR_FILT_BASE + 12'(4 * n), 32'h100 + n, 1'b0);
    wr(ADDR_MASK0, 32'h1fffffff, 1'b0);
    wr(ADDR_MASK1, 32'h1fffffff, 1'b0);
    wr(ADDR_CTRL, 32'h01, 1'b0);
    repeat (3) @(posedge pclk);
    #1 chk("can_tx normal", 0, can_tx);
    tx_dominant <= 1'b0;
    wr(ADDR_FILT_BASE, 32'h555, 1'b1);
    rdc(ADDR_FILT_BASE, 32'h100);
    for (int n = 2; n < 6; n++) send(29'h100 + n, 1'b1, BUF_ONE, 5'(n));
    send(29'h100, 1'b1, BUF_ZERO, HIT_B0_F0);
    rx_buffer_zero_full <= 1'b1;
    send(29'h101, 1'b1, BUF_ZERO, HIT_B0_F1);
    wr(ADDR_CTRL, 32'h11, 1'b0);
    send(29'h100, 1'b1, BUF_ONE, 5'h00);
    send(29'h101, 1'b1, BUF_ONE, 5'h01);
    send(29'h1ff, 1'b0, 4'h0, 5'h00);
    rx_buffer_zero_full <= 1'b0;
    // modes 1 and 2: filter 9 on a loose mask, filter 4 masked by filter fifteen
    wr(ADDR_CTRL, 32'h00, 1'b0);
    for (int n = 0; n < 16; n++) wr(ADDR_FILT_BASE + 12'(4 * n), 32'h200 + n, 1'b0);
    wr(ADDR_MASK1, 32'h1ffffff0, 1'b0);
    wr(ADDR_MSEL, 32'h00040200, 1'b0);
    wr(ADDR_ASSOC0, 32'h89abcdef, 1'b0);
    wr(ADDR_ASSOC1, 32'h01234567, 1'b0);
    wr(ADDR_FEN, 32'h0000fff7, 1'b0);
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_CTRL, 32'h81 | (m << 2), 1'b0);
      send(29'h205, 1'b1, 4'ha, 5'd5);
      send(29'h203, 1'b1, 4'h6, 5'd9);
      send(29'h604, 1'b1, 4'hb, 5'd4);
      send(29'h21f, 1'b0, 4'h0, 5'h00);
    end
    wr(ADDR_ASSOC0, 32'h0, 1'b1);
    wr(ADDR_MSEL, 32'h0, 1'b1);
    // hard sync on an idle falling edge, then a glitch in the same bit
    node.drive(1'b1);
    repeat (30) @(posedge pclk);
    node.drive(1'b0);
    watch(8);
    chk("hard sync count", 1, hs);
    bus_idle <= 1'b0;
    node.drive(1'b1);
    node.drive(1'b0);
    watch(10);
    chk("sync after hard sync", 0, hs + rs);
    watch(12);
    chk("sampled dominant", 0, sampled_bit);
    node.drive(1'b1);
    watch(25);
    chk("sync on rising edge", 0, hs + rs);
    node.drive(1'b0);
    watch(8);
    chk("resync count", 1, rs);
    chk("hard sync off idle", 0, hs);
    // edge after a dominant sample must be ignored
    wait_sp();
    node.drive(1'b1);
    node.drive(1'b0);
    watch(8);
    chk("sync after dominant sample", 0, hs + rs);
    print_verdict();
  end
endmodule : test_can_accept_filter_bit_sync
`default_nettype wire
